// file: rtl/irq_wiring_map.svh
// constants for private, software and message interrupt wiring
`ifndef IRQ_WIRING_MAP_SVH
`define IRQ_WIRING_MAP_SVH

// software generated interrupt range
`define SWI_COUNT           8
`define SWI_LAST            4'h7

// private interrupt window
`define WIN_BASE            5'h10
`define WIN_WIDTH           16

// private interrupt numbers per source
`define NUM_SEC_HYP_VIRT    5'h13
`define NUM_SEC_HYP_PHYS    5'h14
`define NUM_PROFILING       5'h15
`define NUM_DEBUG_CHANNEL   5'h16
`define NUM_PERF_OVERFLOW   5'h17
`define NUM_CROSS_TRIGGER   5'h18
`define NUM_MAINTENANCE     5'h19
`define NUM_HYP_PHYS        5'h1a
`define NUM_VIRT_TIMER      5'h1b
`define NUM_HYP_VIRT        5'h1c
`define NUM_SEC_PHYS        5'h1d
`define NUM_NS_PHYS         5'h1e
`define NUM_TRACE_OVERFLOW  5'h11

// core count ceilings per controller version
`define MAX_CORES_V2        32'h0000_0008
`define MAX_CORES_V3        32'h1000_0000

// message interrupt targets
`define SPI_MSG_BASE        10'h040
`define SPI_MSG_MASK        10'h03f
`define MBI_BASE            32'h0000_2000
`define LEGACY_LINES        4

`endif

// file: rtl/irq_wiring_pkg.sv
// types shared by the interrupt wiring modules
package irq_wiring_pkg;

  typedef enum logic [1:0] {
    ctrl_v2,
    ctrl_v2_msg,
    ctrl_v3
  } ctrl_variant_t;

  typedef struct packed {
    logic [15:0] win;
  } lane_state_t;

  // private interrupt number to bit position in the 16-wide window
  function automatic logic [3:0] win_index(input logic [4:0] num);
    return num[3:0];
  endfunction : win_index

endpackage : irq_wiring_pkg

// file: rtl/irq_route_if.sv
// per-core private interrupt sources and the resulting window
`timescale 1ns/1ns
interface irq_route_if;
  logic        ns_phys_timer;
  logic        virtual_timer;
  logic        hyp_virtual_timer;
  logic        hyp_physical_timer;
  logic        secure_physical_timer;
  logic        secure_hyp_physical_timer;
  logic        secure_hyp_virtual_timer;
  logic        cross_trigger_irq;
  logic        debug_channel_irq;
  logic        perf_overflow;
  logic        profiling_buffer_irq;
  logic        maintenance_irq;
  logic        trace_overflow;
  logic [15:0] win;

  modport feed (output ns_phys_timer, virtual_timer, hyp_virtual_timer, hyp_physical_timer,
                output secure_physical_timer, secure_hyp_physical_timer,
                output secure_hyp_virtual_timer, cross_trigger_irq, debug_channel_irq,
                output perf_overflow, profiling_buffer_irq, maintenance_irq, trace_overflow,
                input  win);
  modport lane (input  ns_phys_timer, virtual_timer, hyp_virtual_timer, hyp_physical_timer,
                input  secure_physical_timer, secure_hyp_physical_timer,
                input  secure_hyp_virtual_timer, cross_trigger_irq, debug_channel_irq,
                input  perf_overflow, profiling_buffer_irq, maintenance_irq, trace_overflow,
                output win);
endinterface : irq_route_if

// file: rtl/core_irq_lane.sv
// one core's private interrupt lane: sources to window bits
`timescale 1ns/1ns
`include "irq_wiring_map.svh"
module core_irq_lane
  import irq_wiring_pkg::*;
#(
  parameter bit HAS_PROFILING  = 1'b1,
  parameter bit HAS_SECURE_HYP = 1'b0,
  parameter bit HAS_V81        = 1'b1,
  parameter bit HAS_TRACE      = 1'b0,
  parameter bit DIRECT_PERF    = 1'b1
) (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  resetn,
  // sources in, window out
  irq_route_if.lane  rif
);

  lane_state_t cur;
  lane_state_t next_cur;

  always_comb begin
    next_cur = '0;
    next_cur.win[win_index(`NUM_NS_PHYS)]       = rif.ns_phys_timer;
    next_cur.win[win_index(`NUM_VIRT_TIMER)]    = rif.virtual_timer;
    next_cur.win[win_index(`NUM_CROSS_TRIGGER)] = rif.cross_trigger_irq;
    next_cur.win[win_index(`NUM_PERF_OVERFLOW)] = rif.perf_overflow;
    next_cur.win[win_index(`NUM_DEBUG_CHANNEL)] = rif.debug_channel_irq;
    next_cur.win[win_index(`NUM_PROFILING)]     = HAS_PROFILING & rif.profiling_buffer_irq;
    next_cur.win[win_index(`NUM_HYP_VIRT)]      = HAS_V81 & rif.hyp_virtual_timer;
    next_cur.win[win_index(`NUM_HYP_PHYS)]      = rif.hyp_physical_timer;
    next_cur.win[win_index(`NUM_MAINTENANCE)]   = rif.maintenance_irq;
    next_cur.win[win_index(`NUM_SEC_PHYS)]      = rif.secure_physical_timer;
    next_cur.win[win_index(`NUM_SEC_HYP_PHYS)]  = HAS_SECURE_HYP & rif.secure_hyp_physical_timer;
    next_cur.win[win_index(`NUM_SEC_HYP_VIRT)]  = HAS_SECURE_HYP & rif.secure_hyp_virtual_timer;
    next_cur.win[win_index(`NUM_TRACE_OVERFLOW)] = HAS_TRACE & rif.trace_overflow;
  end

  // levels follow their sources, never latched
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  genvar b;
  generate
    for (b = 0; b < `WIN_WIDTH; b++) begin : g_bit
      if (DIRECT_PERF && (b == int'(win_index(`NUM_PERF_OVERFLOW)))) begin : g_direct
        // overflow bypasses the register on version 3 controllers
        assign rif.win[b] = rif.perf_overflow;
      end else begin : g_reg
        assign rif.win[b] = cur.win[b];
      end
    end
  endgenerate

endmodule : core_irq_lane

// file: rtl/irq_wiring_map.sv
// interrupt wiring map: per-core private lines, software and message interrupts
//
// Behaviour
// - controller variant is version 2, version 2 with message extension, or version 3.
// - plain version 2 takes no PCIe; extension turns messages into shared interrupts.
// - version 3 without translation service is legal only without PCIe.
// - PCIe with version 3 needs translation service and message-based interrupts.
// - version 3 controller supports Secure and Non-secure interrupt handling.
// - with version 3 and PCIe, messages preferably become message-based interrupts.
// - PCIe legacy interrupts are delivered as level-sensitive wired lines.
// - eight Non-secure software interrupts exist at numbers zero to seven.
// - private interrupts sit within numbers sixteen to thirty-one.
// - Non-secure physical timer drives private interrupt thirty.
// - virtual timer drives private interrupt twenty-seven.
// - cross-trigger interrupt drives private interrupt twenty-four.
// - performance counter overflow drives private interrupt twenty-three.
// - debug channel interrupt drives private interrupt twenty-two.
// - profiling buffer interrupt drives twenty-one when profiling exists.
// - hypervisor virtual timer drives twenty-eight on revision 8.1 or later cores.
// - hypervisor physical timer drives private interrupt twenty-six.
// - controller maintenance interrupt drives private interrupt twenty-five.
// - Secure physical timer drives private interrupt twenty-nine.
// - Secure hypervisor physical timer drives twenty when that level exists.
// - Secure hypervisor virtual timer drives nineteen when that level exists.
// - one extra private interrupt may be reserved for trace overflow.
// - at most eight cores on version 2, two to the twenty-eight on version 3.
// - on version 3, each core's overflow reaches its own line with no logic.
`timescale 1ns/1ns
`include "irq_wiring_map.svh"
module irq_wiring_map
  import irq_wiring_pkg::*;
#(
  parameter ctrl_variant_t VARIANT       = ctrl_v3,
  parameter bit            HAS_TRANSLATE = 1'b1,
  parameter bit            HAS_MSG_IRQ   = 1'b1,
  parameter bit            HAS_TWO_SEC   = 1'b1,
  parameter bit            HAS_PCIE      = 1'b1,
  parameter int            NUM_CORES     = 4,
  parameter bit            HAS_PROFILING = 1'b1,
  parameter bit            HAS_SEC_HYP   = 1'b0,
  parameter bit            HAS_V81       = 1'b1,
  parameter bit            HAS_TRACE     = 1'b0
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    resetn,
  // per-core private sources, one bit per core
  input  wire logic [NUM_CORES-1:0]    ns_phys_timer,
  input  wire logic [NUM_CORES-1:0]    virtual_timer,
  input  wire logic [NUM_CORES-1:0]    hyp_virtual_timer,
  input  wire logic [NUM_CORES-1:0]    hyp_physical_timer,
  input  wire logic [NUM_CORES-1:0]    secure_physical_timer,
  input  wire logic [NUM_CORES-1:0]    secure_hyp_physical_timer,
  input  wire logic [NUM_CORES-1:0]    secure_hyp_virtual_timer,
  input  wire logic [NUM_CORES-1:0]    cross_trigger_irq,
  input  wire logic [NUM_CORES-1:0]    debug_channel_irq,
  input  wire logic [NUM_CORES-1:0]    perf_overflow,
  input  wire logic [NUM_CORES-1:0]    profiling_buffer_irq,
  input  wire logic [NUM_CORES-1:0]    maintenance_irq,
  input  wire logic [NUM_CORES-1:0]    trace_overflow,
  // private interrupt windows, 16 lines per core
  output logic [NUM_CORES*16-1:0]      private_peripheral_interrupt,
  // software generated interrupt request and acknowledge
  input  wire logic                    swi_req,
  input  wire logic [31:0]             swi_target,
  input  wire logic [3:0]              swi_number,
  output logic                         swi_req_ready,
  input  wire logic [NUM_CORES-1:0]    swi_ack,
  input  wire logic [3:0]              swi_ack_number,
  output logic [NUM_CORES*8-1:0]       software_generated_interrupt,
  // PCIe message interrupts in
  input  wire logic                    msg_valid,
  input  wire logic [27:0]             msg_event,
  output logic                         msg_ready,
  // shared interrupt out for converted messages
  output logic                         spi_valid,
  output logic [9:0]                   spi_number,
  // message-based interrupt out
  output logic                         message_based_interrupt_valid,
  output logic [31:0]                  message_based_interrupt_number,
  // PCIe legacy lines in, wired levels out
  input  wire logic [`LEGACY_LINES-1:0] legacy_in,
  output logic [`LEGACY_LINES-1:0]     legacy_level,
  // configuration status
  output logic                         msg_dropped,
  output logic                         config_error,
  output logic                         two_security_states
);

  // ----------------------------------------------------------------------
  // configuration checks
  // ----------------------------------------------------------------------

  localparam bit IS_V3 = (VARIANT == ctrl_v3);

  // only the three enumerated variants exist
  localparam bit VARIANT_OK = (VARIANT == ctrl_v2) || (VARIANT == ctrl_v2_msg)
                              || (VARIANT == ctrl_v3);

  // plain version 2 cannot carry PCIe
  localparam bit V2_OK = !((VARIANT == ctrl_v2) && HAS_PCIE);

  // version 3 without translation only in PCIe-free systems
  localparam bit V3_BARE_OK = !(IS_V3 && !HAS_TRANSLATE && HAS_PCIE);

  // PCIe with version 3 needs translation and message interrupts
  localparam bit V3_PCIE_OK = !(IS_V3 && HAS_PCIE && !(HAS_TRANSLATE && HAS_MSG_IRQ));

  // version 3 must offer both security states
  localparam bit V3_SEC_OK = !(IS_V3 && !HAS_TWO_SEC);

  // core count ceiling per version
  localparam bit CORES_OK = IS_V3 ? (32'(NUM_CORES) <= `MAX_CORES_V3)
                                  : (32'(NUM_CORES) <= `MAX_CORES_V2);

  localparam bit CONFIG_OK = VARIANT_OK && V2_OK && V3_BARE_OK && V3_PCIE_OK
                             && V3_SEC_OK && CORES_OK && (NUM_CORES > 0);

  // message handling route chosen from the variant
  localparam bit MSG_TO_SPI = (VARIANT == ctrl_v2_msg) && HAS_PCIE;
  localparam bit MSG_TO_MBI = IS_V3 && HAS_PCIE && HAS_TRANSLATE && HAS_MSG_IRQ;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------

  typedef struct packed {
    logic [NUM_CORES*8-1:0]    swi_pending;
    logic                      spi_valid;
    logic [9:0]                spi_number;
    logic                      mbi_valid;
    logic [31:0]               mbi_number;
    logic [`LEGACY_LINES-1:0]  legacy;
    logic                      msg_dropped;
    logic                      config_error;
    logic                      two_sec;
  } top_state_t;

  top_state_t cur;
  top_state_t next_cur;

  // software interrupt request is legal for numbers 0..7 and an existing core
  function automatic logic swi_in_range(input logic [3:0] num);
    return num <= `SWI_LAST;
  endfunction : swi_in_range

  logic swi_take;

  assign swi_take      = swi_req && swi_in_range(swi_number)
                         && (swi_target < 32'(NUM_CORES));
  assign swi_req_ready = 1'b1;
  assign msg_ready     = 1'b1;

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------

  always_comb begin
    next_cur = cur;

    // pulses last one cycle
    next_cur.spi_valid   = 1'b0;
    next_cur.mbi_valid   = 1'b0;
    next_cur.msg_dropped = 1'b0;

    // software interrupts: acknowledge clears, a new request wins
    for (int c = 0; c < NUM_CORES; c++) begin
      if (swi_ack[c] && swi_in_range(swi_ack_number)) begin
        next_cur.swi_pending[c*8 + int'(swi_ack_number[2:0])] = 1'b0;
      end
    end
    if (swi_take) begin
      for (int c = 0; c < NUM_CORES; c++) begin
        if (swi_target == 32'(c)) begin
          next_cur.swi_pending[c*8 + int'(swi_number[2:0])] = 1'b1;
        end
      end
    end

    // message interrupts routed by variant
    if (msg_valid) begin
      if (MSG_TO_MBI) begin
        next_cur.mbi_valid  = 1'b1;
        next_cur.mbi_number = `MBI_BASE + {4'h0, msg_event};
      end else if (MSG_TO_SPI) begin
        next_cur.spi_valid  = 1'b1;
        next_cur.spi_number = `SPI_MSG_BASE + (msg_event[9:0] & `SPI_MSG_MASK);
      end else begin
        // no message path in this configuration
        next_cur.msg_dropped = 1'b1;
      end
    end

    // legacy lines stay level-sensitive, follow the root complex
    next_cur.legacy = HAS_PCIE ? legacy_in : '0;

    next_cur.config_error = !CONFIG_OK;
    next_cur.two_sec      = IS_V3 ? HAS_TWO_SEC : 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------------
  // per-core private interrupt lanes
  // ----------------------------------------------------------------------

  genvar c;
  generate
    for (c = 0; c < NUM_CORES; c++) begin : g_core
      irq_route_if rif ();

      // each core's sources reach only its own lane
      assign rif.ns_phys_timer             = ns_phys_timer[c];
      assign rif.virtual_timer             = virtual_timer[c];
      assign rif.hyp_virtual_timer         = hyp_virtual_timer[c];
      assign rif.hyp_physical_timer        = hyp_physical_timer[c];
      assign rif.secure_physical_timer     = secure_physical_timer[c];
      assign rif.secure_hyp_physical_timer = secure_hyp_physical_timer[c];
      assign rif.secure_hyp_virtual_timer  = secure_hyp_virtual_timer[c];
      assign rif.cross_trigger_irq         = cross_trigger_irq[c];
      assign rif.debug_channel_irq         = debug_channel_irq[c];
      assign rif.perf_overflow             = perf_overflow[c];
      assign rif.profiling_buffer_irq      = profiling_buffer_irq[c];
      assign rif.maintenance_irq           = maintenance_irq[c];
      assign rif.trace_overflow            = trace_overflow[c];

      core_irq_lane #(
        .HAS_PROFILING  (HAS_PROFILING),
        .HAS_SECURE_HYP (HAS_SEC_HYP),
        .HAS_V81        (HAS_V81),
        .HAS_TRACE      (HAS_TRACE),
        .DIRECT_PERF    (IS_V3)
      ) u_lane (
        .clk    (clk),
        .resetn (resetn),
        .rif    (rif)
      );

      // window bit k is interrupt number 16 + k
      assign private_peripheral_interrupt[c*16 +: 16] = rif.win;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------

  assign software_generated_interrupt   = cur.swi_pending;
  assign spi_valid                      = cur.spi_valid;
  assign spi_number                     = cur.spi_number;
  assign message_based_interrupt_valid  = cur.mbi_valid;
  assign message_based_interrupt_number = cur.mbi_number;
  assign legacy_level                   = cur.legacy;
  assign msg_dropped                    = cur.msg_dropped;
  assign config_error                   = cur.config_error;
  assign two_security_states            = cur.two_sec;

endmodule : irq_wiring_map

// file: verification/irq_wiring_map_props.sv
// concurrent assertions on the interrupt wiring map ports
`timescale 1ns/1ns
`include "irq_wiring_map.svh"
module irq_wiring_map_props
  import irq_wiring_pkg::*;
#(
  parameter int NUM_CORES = 4,
  parameter bit HAS_TRACE = 1'b0
) (
  // clock and reset
  input wire logic                     clk,
  input wire logic                     resetn,
  // private sources and windows
  input wire logic [NUM_CORES-1:0]     ns_phys_timer,
  input wire logic [NUM_CORES-1:0]     cross_trigger_irq,
  input wire logic [NUM_CORES-1:0]     perf_overflow,
  input wire logic [NUM_CORES*16-1:0]  private_peripheral_interrupt,
  // software interrupts
  input wire logic                     swi_req,
  input wire logic [31:0]              swi_target,
  input wire logic [3:0]               swi_number,
  input wire logic [NUM_CORES-1:0]     swi_ack,
  input wire logic [3:0]               swi_ack_number,
  input wire logic [NUM_CORES*8-1:0]   software_generated_interrupt,
  // messages, legacy lines and status
  input wire logic                     msg_valid,
  input wire logic [27:0]              msg_event,
  input wire logic                     spi_valid,
  input wire logic                     message_based_interrupt_valid,
  input wire logic [31:0]              message_based_interrupt_number,
  input wire logic [`LEGACY_LINES-1:0] legacy_in,
  input wire logic [`LEGACY_LINES-1:0] legacy_level,
  input wire logic                     config_error,
  input wire logic                     two_security_states
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------
  // window bits that no source may drive
  // ----------------------------------------
  logic unused_bits;
  always_comb begin
    unused_bits = 1'b0;
    for (int c = 0; c < NUM_CORES; c++) begin
      unused_bits |= |(private_peripheral_interrupt[c*16+:16] & (HAS_TRACE ? 16'h8005 : 16'h8007));
    end
  end

  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_swi_take;
    swi_req && swi_number <= 4'h7 && swi_target < NUM_CORES;
  endsequence
  sequence s_swi_drop;
    swi_req && (swi_number > 4'h7 || swi_target >= NUM_CORES) && swi_ack == '0;
  endsequence
  sequence s_msg_in;
    msg_valid;
  endsequence

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_ns_phys_map: assert property (ns_phys_timer[0] |=> private_peripheral_interrupt[14])
    else $error("timer line not on window bit 14");
  a_own_core_only: assert property (!cross_trigger_irq[1] |=> !private_peripheral_interrupt[24])
    else $error("cross trigger seen on wrong core");
  a_perf_direct: assert property (private_peripheral_interrupt[7] == perf_overflow[0])
    else $error("overflow line not direct");
  a_window_unused: assert property (!unused_bits)
    else $error("unused window bit driven");
  a_swi_set: assert property (s_swi_take |=>
    software_generated_interrupt[$past(swi_target)*8+$past(swi_number)])
    else $error("software interrupt not pending");
  a_swi_refused: assert property (s_swi_drop |=> $stable(software_generated_interrupt))
    else $error("refused request changed pending");
  a_swi_holds: assert property (software_generated_interrupt[11]
    && !(swi_ack[1] && swi_ack_number == 4'h3) |=> software_generated_interrupt[11])
    else $error("pending bit lost without ack");
  a_msg_number: assert property (s_msg_in |=> message_based_interrupt_valid && !spi_valid
    && message_based_interrupt_number == 32'h0000_2000 + $past(msg_event))
    else $error("message not converted");
  a_msg_single: assert property (!msg_valid |=> !message_based_interrupt_valid)
    else $error("message output stands too long");
  a_legacy_copy: assert property (1'b1 |=> legacy_level == $past(legacy_in))
    else $error("legacy level not copied");
  a_config_legal: assert property (1'b1 |=> !config_error && two_security_states)
    else $error("legal set reported wrong");
endmodule : irq_wiring_map_props

bind irq_wiring_map irq_wiring_map_props #(.NUM_CORES(NUM_CORES), .HAS_TRACE(HAS_TRACE)) u_props (
  .clk, .resetn, .ns_phys_timer, .cross_trigger_irq, .perf_overflow,
  .private_peripheral_interrupt, .swi_req, .swi_target, .swi_number, .swi_ack,
  .swi_ack_number, .software_generated_interrupt, .msg_valid, .msg_event, .spi_valid,
  .message_based_interrupt_valid, .message_based_interrupt_number, .legacy_in,
  .legacy_level, .config_error, .two_security_states
);

// file: verification/core_ack_model.sv
// far-side core model that acknowledges software interrupts
`timescale 1ns/1ns
module core_ack_model #(
  parameter int NUM_CORES = 2
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // command from the bench
  input  wire logic                 go,
  input  wire logic [31:0]          core,
  input  wire logic [3:0]           num,
  input  wire logic [3:0]           delay,
  // acknowledge towards the block
  output logic [NUM_CORES-1:0]      swi_ack,
  output logic [3:0]                swi_ack_number
);
  logic        act;
  logic [3:0]  cnt;
  logic [31:0] c;
  logic [3:0]  n;
  always @(posedge clk) begin
    if (!resetn) begin
      act <= 1'b0;
      cnt <= 4'h0;
    end else if (go) begin
      act <= 1'b1;
      cnt <= delay;
      c   <= core;
      n   <= num;
    end else if (act && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else begin
      act <= 1'b0;
    end
  end
  assign swi_ack = (act && cnt == 4'h0) ? ({{(NUM_CORES-1){1'b0}}, 1'b1} << c) : '0;
  // number is inverted outside the pulse
  assign swi_ack_number = (act && cnt == 4'h0) ? n : ~n;
endmodule : core_ack_model

// file: verification/irq_wiring_map_tb.sv
// self-checking bench for the interrupt wiring map
`timescale 1ns/1ns
module irq_wiring_map_tb;
  import irq_wiring_pkg::*;
  localparam int NC = 2;
  localparam int POS [13] = '{14, 11, 12, 10, 13, 4, 3, 8, 6, 7, 5, 9, 1};
  logic          clk = 1'b0, resetn = 1'b0, swi_req = 1'b0, msg_valid = 1'b0, go = 1'b0;
  logic [NC-1:0] src [13] = '{default: '0};
  logic [NC-1:0] swi_ack;
  logic [31:0]   swi_target = 32'h0, ack_core = 32'h0, win, mbi_num;
  logic [3:0]    swi_number = 4'h0, ack_num = 4'h0, ack_delay = 4'h0, swi_ack_number;
  logic [3:0]    legacy_in = 4'h0, legacy_level;
  logic [27:0]   msg_event = 28'h0;
  logic [15:0]   swi_out;
  logic [9:0]    spi_num;
  logic          swi_ready, msg_ready, spi_valid, mbi_valid, dropped, cfg_err, two_sec;
  int            checks = 0, bad_count = 0;

  always #4 clk = ~clk;

  irq_wiring_map #(.NUM_CORES(NC), .HAS_SEC_HYP(1'b1)) dut (
    .clk(clk), .resetn(resetn), .ns_phys_timer(src[0]), .virtual_timer(src[1]),
    .hyp_virtual_timer(src[2]), .hyp_physical_timer(src[3]), .secure_physical_timer(src[4]),
    .secure_hyp_physical_timer(src[5]), .secure_hyp_virtual_timer(src[6]),
    .cross_trigger_irq(src[7]), .debug_channel_irq(src[8]), .perf_overflow(src[9]),
    .profiling_buffer_irq(src[10]), .maintenance_irq(src[11]), .trace_overflow(src[12]),
    .private_peripheral_interrupt(win), .swi_req(swi_req), .swi_target(swi_target),
    .swi_number(swi_number), .swi_req_ready(swi_ready), .swi_ack(swi_ack),
    .swi_ack_number(swi_ack_number), .software_generated_interrupt(swi_out),
    .msg_valid(msg_valid), .msg_event(msg_event), .msg_ready(msg_ready),
    .spi_valid(spi_valid), .spi_number(spi_num), .message_based_interrupt_valid(mbi_valid),
    .message_based_interrupt_number(mbi_num), .legacy_in(legacy_in),
    .legacy_level(legacy_level), .msg_dropped(dropped), .config_error(cfg_err),
    .two_security_states(two_sec));

  core_ack_model #(.NUM_CORES(NC)) u_cores (
    .clk(clk), .resetn(resetn), .go(go), .core(ack_core), .num(ack_num),
    .delay(ack_delay), .swi_ack(swi_ack), .swi_ack_number(swi_ack_number));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic reset_dut();
    resetn = 1'b0;
    repeat (10) step();
    resetn = 1'b1;
  endtask : reset_dut

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic ack_swi(input logic [31:0] c, input logic [3:0] n, input logic [3:0] d);
    go = 1'b1;
    ack_core = c;
    ack_num = n;
    ack_delay = d;
    step();
    go = 1'b0;
    repeat (d + 1) step();
  endtask : ack_swi

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_private_map();
    logic [31:0] exp;
    for (int s = 0; s < 13; s++) begin
      for (int c = 0; c < NC; c++) begin
        exp = (s == 12) ? 32'h0 : (32'h1 << (c * 16 + POS[s]));
        src[s][c] = 1'b1;
        step();
        check("private window", win, exp);
        src[s][c] = 1'b0;
        step();
        check("window released", win, 32'h0);
      end
    end
    $display("test_private_map done");
  endtask : test_private_map

  task automatic test_perf_direct();
    src[9][0] = 1'b1;
    #1;
    check("overflow same cycle", win[7], 1'b1);
    src[9][0] = 1'b0;
    #1;
    check("overflow dropped", win[7], 1'b0);
    step();
    $display("test_perf_direct done");
  endtask : test_perf_direct

  task automatic test_swi();
    swi_req = 1'b1;
    swi_target = 32'h1;
    for (int n = 0; n < 8; n++) begin
      swi_number = n[3:0];
      step();
    end
    swi_number = 4'h8;
    step();
    swi_number = 4'h2;
    swi_target = 32'h2;
    step();
    swi_req = 1'b0;
    check("soft irq pending", swi_out, 16'hff00);
    ack_swi(32'h1, 4'h3, 4'h0);
    check("soft irq prompt ack", swi_out, 16'hf700);
    ack_swi(32'h1, 4'h7, 4'h5);
    check("soft irq slow ack", swi_out, 16'h7700);
    $display("test_swi done");
  endtask : test_swi

  task automatic test_msg();
    msg_valid = 1'b1;
    msg_event = 28'h5;
    step();
    check("msg number", mbi_num, 32'h0000_2005);
    msg_event = 28'hfff_ffff;
    step();
    msg_valid = 1'b0;
    check("msg top number", mbi_num, 32'h1000_1fff);
    check("msg route", {spi_valid, dropped, mbi_valid}, 3'b001);
    check("shared number idle", spi_num, 10'h000);
    step();
    check("msg one cycle", mbi_valid, 1'b0);
    $display("test_msg done");
  endtask : test_msg

  task automatic test_legacy_cfg();
    legacy_in = 4'h5;
    step();
    check("legacy level", legacy_level, 4'h5);
    legacy_in = 4'ha;
    step();
    check("legacy level", legacy_level, 4'ha);
    check("config status", {cfg_err, two_sec, swi_ready, msg_ready}, 4'h7);
    $display("test_legacy_cfg done");
  endtask : test_legacy_cfg

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    reset_dut();
    test_private_map();
    test_perf_direct();
    test_swi();
    reset_dut();
    test_msg();
    test_legacy_cfg();
    report_and_stop();
  end

  initial begin
    #50000;
    bad_count++;
    report_and_stop();
  end
endmodule : irq_wiring_map_tb
